// ### bench/p12pc_pin_model.sv
// Package pin model for one 8-bit port: resolves each pin's level.
// Assumes the design drives where oe_n is low; elsewhere outside drive where enabled, else pull-up or none.
`timescale 1ns/1ps
`default_nettype none

module p12pc_pin_model (
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] pin_oe_n_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic [7:0] ext_val_in,
  input  wire logic [7:0] ext_en_in,
  input  wire logic       mclk_in,
  output logic      [7:0] level_out
);
  logic [7:0] float_ff = 8'h55;

  // A released pin with no outside drive and no pull-up keeps no level: it toggles every cycle
  always_ff @(posedge mclk_in) begin
    float_ff <= ~float_ff;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n_in[i]) level_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pullup_in[i]) level_out[i] = 1'b1;
      else level_out[i] = float_ff[i];
    end
  end
endmodule // p12pc_pin_model

`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the port 1 / port 2 pin control block.
// Assumes p12pc_defines.svh on the include path and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "p12pc_defines.svh"

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  logic        mclk_in, rst_n_in, read_in, write_in, waitrequest_out, pwm, external_interrupt_six, external_interrupt_seven;
  logic [9:0]  address_in;
  logic [31:0] writedata_in, readdata_out;
  logic [3:0]  byteenable_in;
  logic [7:0]  p1_in, p1_out, p1_oe_n, p1_pu, p2_in, p2_out, p2_oe_n, p2_data;
  logic [7:0]  ext_val;
  logic [5:0]  upper_push, an_sel;
  int          num_errors, check_count;

  p12pc_top #(.ADDR_W(10)) i_p12pc_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(byteenable_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .port1_pin_in(p1_in), .port1_pin_out(p1_out), .port1_pin_oe_n_out(p1_oe_n),
    .port1_pullup_enable_out(p1_pu), .port1_upper_push_in(upper_push),
    .port2_pin_in(p2_in), .port2_pin_out(p2_out), .port2_pin_oe_n_out(p2_oe_n),
    .port2_data_in(p2_data), .pwm_channel_two_output_in(pwm),
    .external_interrupt_six_out(external_interrupt_six), .external_interrupt_seven_out(external_interrupt_seven),
    .analog_select_out(an_sel));

  p12pc_pin_model u_p1_pins (.pin_out_in(p1_out), .pin_oe_n_in(p1_oe_n), .pullup_in(p1_pu),
    .ext_val_in(ext_val), .ext_en_in(8'hff), .mclk_in(mclk_in), .level_out(p1_in));
  p12pc_pin_model u_p2_pins (.pin_out_in(p2_out), .pin_oe_n_in(p2_oe_n), .pullup_in(8'h00),
    .ext_val_in(8'h00), .ext_en_in(8'h00), .mclk_in(mclk_in), .level_out(p2_in));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // --------------------------------------------------------------------------
  // Bus and helper tasks
  // --------------------------------------------------------------------------
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    address_in    <= {idx, 2'b00};
    write_in      <= wr;
    read_in       <= !wr;
    writedata_in  <= {24'h0, d};
    byteenable_in <= be;
    do begin
      @(posedge mclk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    q = readdata_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, idx, d, 4'h1, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] ex);
    logic [31:0] q;
    bus_xfer(1'b0, idx, 8'h00, 4'hf, q);
    `CHK(nm, ex, q)
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    upper_push <= 6'h3f;
    rst_n_in   <= 1'b0;
    repeat (16) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    settle();
    `CHK("p1_out_hi", 6'h3e, p1_out[7:2])
    `CHK("p1_oe_n", 8'h03, p1_oe_n)
    `CHK("ext_six_seven", 2'b11, {external_interrupt_six, external_interrupt_seven})
    `CHK("p2_oe_n", p2_data, p2_oe_n)
    `CHK("pullup_out", 8'h00, p1_pu)
    `CHK("analog", 6'h00, an_sel)
    rd_chk("p1_ctrl", `P12PC_IDX_P1_CTRL_LOW, 32'h00);
    rd_chk("pullup", `P12PC_IDX_P1_PULLUP, 32'h00);
    rd_chk("p2_high", `P12PC_IDX_P2_CTRL_HIGH, 32'h55);
    rd_chk("p2_low", `P12PC_IDX_P2_CTRL_LOW, 32'h55);
    rd_chk("unmapped", 8'h00, 32'h00);
  endtask

  // Pin 1 walks all eight codes; pin 0 follows with the low two bits
  task automatic t_p1_modes;
    logic [2:0] c;
    logic [1:0] d;
    logic [1:0] oe;
    upper_push <= 6'h00;
    wr(`P12PC_IDX_P1_DATA, 8'ha4);
    for (int k = 0; k < 8; k++) begin
      c  = k[2:0];
      d  = c[1:0];
      oe = {c == 3'h0 || c == 3'h2, d == 2'h0 || d == 2'h2};
      wr(`P12PC_IDX_P1_CTRL_LOW, (c == 3'h7) ? 8'hff : {3'h0, c, d});
      settle();
      `CHK("p1_oe_n_lo", oe, p1_oe_n[1:0])
      `CHK("p1_out_lo", {c == 3'h3, 1'b0} & ~oe, p1_out[1:0] & ~oe)
      `CHK("analog_lo", {d == 2'h2, c == 3'h2}, an_sel[1:0])
      `CHK("ext_seven", c == 3'h0, external_interrupt_seven)
      `CHK("ext_six", d == 2'h0, external_interrupt_six)
      rd_chk("p1_ctrl", `P12PC_IDX_P1_CTRL_LOW, {27'h0, c, d});
      rd_chk("p1_data", `P12PC_IDX_P1_DATA,
             {24'h0, 6'h16, !(c == 3'h1 || c[2]), !(d == 2'h1 || d == 2'h3)});
      // Pull the far-side levels low: events and PWM drive must follow them
      pwm     <= 1'b0;
      ext_val <= 8'h58;
      settle();
      `CHK("ext_low", 2'b00, {external_interrupt_six, external_interrupt_seven})
      `CHK("pwm_low", 1'b0, (c == 3'h3) ? p1_out[1] : 1'b0)
      @(posedge mclk_in);
      pwm     <= 1'b1;
      ext_val <= 8'h5b;
    end
  endtask

  task automatic t_pullup;
    logic [31:0] q;
    wr(`P12PC_IDX_P1_PULLUP, 8'ha5);
    bus_xfer(1'b1, `P12PC_IDX_P1_PULLUP, 8'h00, 4'h0, q);
    settle();
    `CHK("pullup_out", 8'ha5, p1_pu)
    rd_chk("pullup", `P12PC_IDX_P1_PULLUP, 32'ha5);
    upper_push <= 6'h3f;
    wr(`P12PC_IDX_P1_DATA, 8'hd4);
    settle();
    `CHK("p1_push_hi", {6'h00, 6'h35}, {p1_oe_n[7:2], p1_out[7:2]})
  endtask

  task automatic t_p2_modes;
    logic [1:0] k;
    logic [7:0] oe;
    for (int i = 0; i < 4; i++) begin
      k  = i[1:0];
      oe = (k == 2'h1) ? p2_data : (k == 2'h3) ? 8'h00 : 8'hff;
      wr(`P12PC_IDX_P2_CTRL_HIGH, {4{k}});
      wr(`P12PC_IDX_P2_CTRL_LOW, {4{k}});
      settle();
      `CHK("p2_oe_n", oe, p2_oe_n)
      `CHK("p2_out", p2_data & ~oe, p2_out & ~oe)
      `CHK("analog_p2", (k == 2'h2) ? 4'hf : 4'h0, an_sel[5:2])
      rd_chk("p2_high", `P12PC_IDX_P2_CTRL_HIGH, {24'h0, {4{k}}});
      rd_chk("p2_low", `P12PC_IDX_P2_CTRL_LOW, {24'h0, {4{k}}});
    end
  endtask

  // --------------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------------
  task automatic close_out;
    $display("Mismatches %0d, comparisons %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    num_errors    = 0;
    check_count   = 0;
    rst_n_in      = 1'b0;
    read_in       = 1'b0;
    write_in      = 1'b0;
    address_in    = 10'h000;
    writedata_in  = 32'h0;
    byteenable_in = 4'h0;
    upper_push    = 6'h3f;
    ext_val       = 8'h5b;
    p2_data       = 8'h3c;
    pwm           = 1'b1;
    t_reset();
    t_p1_modes();
    t_pullup();
    t_p2_modes();
    t_reset();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    close_out();
  end
endmodule // tb_top

`default_nettype wire

// ### verilog/p12pc_defines.svh
// Constants for the port 1 / port 2 pin control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.
// Function
// [RQ1] Port 1 low control resets to zero
// [RQ2] Pin1 field: input, open-drain, analog, PWM, push-pull
// [RQ3] Pin0 field: input, open-drain, reference, push-pull
// [RQ4] Software also enables peripheral for alternative functions
// [RQ5] Pull-up bits enable each port 1 pull-up
// [RQ6] Data read gives pin level for inputs
// [RQ7] Port 2 high control resets to 55H
// [RQ8] Port 2 high fields; code 10 analog, pin4 none
// [RQ9] Port 2 low control resets to 55H
// [RQ10] Port 2 low fields; code 10 analog on pin0
// [RQ11] Open-drain pulls low on 0, releases on 1
// [RQ12] Unavailable code leaves driver disabled
`ifndef P12PC_DEFINES_SVH
`define P12PC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define P12PC_IDX_P1_DATA      8'hc1
`define P12PC_IDX_P1_CTRL_LOW  8'hd5
`define P12PC_IDX_P1_PULLUP    8'hd6
`define P12PC_IDX_P2_CTRL_HIGH 8'hd8
`define P12PC_IDX_P2_CTRL_LOW  8'hd9

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define P12PC_RST_P1_DATA      8'hf8
`define P12PC_RST_P1_CTRL_LOW  8'h00
`define P12PC_RST_P1_PULLUP    8'h00
`define P12PC_RST_P2_CTRL_HIGH 8'h55
`define P12PC_RST_P2_CTRL_LOW  8'h55

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define P12PC_P1_PIN0_LSB  0
`define P12PC_P1_PIN1_LSB  2
`define P12PC_P1_CTRL_MASK 8'h1f
`define P12PC_CODE2_INPUT  2'h0
`define P12PC_CODE2_ODRAIN 2'h1
`define P12PC_CODE2_ALT    2'h2
`define P12PC_CODE2_PUSH   2'h3
`define P12PC_CODE3_ANALOG 3'h2
`define P12PC_CODE3_PWM    3'h3

// Analog select bit positions
`define P12PC_AN_CH6  0
`define P12PC_AN_VREF 1
`define P12PC_AN_CH9  2
`define P12PC_AN_CH10 3
`define P12PC_AN_CH11 4
`define P12PC_AN_CH12 5

`endif

// ### verilog/p12pc_pin_if.sv
// Carrier between the register file and the pin mode decoder.
// Assumes pins 0..7 are port 1 and 8..15 are port 2.
`timescale 1ns/1ps
`default_nettype none

interface p12pc_pin_if;
  logic [7:0]  p1_ctrl;
  logic [7:0]  p2_ctrl_low;
  logic [7:0]  p2_ctrl_high;
  logic [15:0] data;
  logic [5:0]  p1_upper_push;
  logic        pwm_level;
  logic [15:0] drive_en;
  logic [15:0] drive_val;
  logic [15:0] out_mode;
  logic [15:0] sense_mode;
  logic [5:0]  analog_sel;

  modport regs (output p1_ctrl, output p2_ctrl_low, output p2_ctrl_high, output data,
                output p1_upper_push, output pwm_level, input drive_en, input drive_val,
                input out_mode, input sense_mode, input analog_sel);
  modport dec  (input p1_ctrl, input p2_ctrl_low, input p2_ctrl_high, input data,
                input p1_upper_push, input pwm_level, output drive_en, output drive_val,
                output out_mode, output sense_mode, output analog_sel);
endinterface

`default_nettype wire

// ### verilog/p12pc_pin_mode.sv
// Pin mode decoder: control fields and data bits to driver controls.
// Assumes the caller registers every result before it reaches a pin.
`timescale 1ns/1ps
`default_nettype none

module p12pc_pin_mode (
  p12pc_pin_if.dec pins
);
  import p12pc_pkg::*;

  p12pc_mode_e mode [16];

  // --------------------------------------------------------------------------
  // Per-pin mode
  // --------------------------------------------------------------------------
  always_comb begin
    for (int i = 2; i < 8; i++) begin
      mode[i] = pins.p1_upper_push[i-2] ? P12PC_PUSH : P12PC_INPUT;
    end
    mode[0] = p12pc_dec2(pins.p1_ctrl[`P12PC_P1_PIN0_LSB +: 2], 1'b1); // RQ3
    mode[1] = p12pc_dec3(pins.p1_ctrl[`P12PC_P1_PIN1_LSB +: 3]);       // RQ2
    for (int i = 0; i < 4; i++) begin
      mode[8+i]  = p12pc_dec2(pins.p2_ctrl_low[2*i +: 2], i == 0);     // RQ10
      mode[12+i] = p12pc_dec2(pins.p2_ctrl_high[2*i +: 2], i != 0);    // RQ8
    end
  end

  // --------------------------------------------------------------------------
  // Driver controls
  // --------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pins.drive_en[i]   = 1'b0;
      pins.drive_val[i]  = 1'b0;
      pins.out_mode[i]   = (mode[i] == P12PC_ODRAIN) || (mode[i] == P12PC_PUSH);
      pins.sense_mode[i] = (mode[i] == P12PC_INPUT);
      unique case (mode[i])
        P12PC_ODRAIN: begin
          pins.drive_en[i] = !pins.data[i]; // RQ11
        end
        P12PC_PUSH: begin
          pins.drive_en[i]  = 1'b1;
          pins.drive_val[i] = pins.data[i];
        end
        P12PC_PWM: begin
          pins.drive_en[i]  = 1'b1;
          pins.drive_val[i] = pins.pwm_level;
        end
        P12PC_INPUT, P12PC_ANALOG, P12PC_NONE: begin
          pins.drive_en[i] = 1'b0; // RQ12
        end
      endcase
    end
    pins.analog_sel[`P12PC_AN_CH6]  = (mode[1] == P12PC_ANALOG);
    pins.analog_sel[`P12PC_AN_VREF] = (mode[0] == P12PC_ANALOG);
    pins.analog_sel[`P12PC_AN_CH9]  = (mode[8] == P12PC_ANALOG);
    pins.analog_sel[`P12PC_AN_CH10] = (mode[13] == P12PC_ANALOG);
    pins.analog_sel[`P12PC_AN_CH11] = (mode[14] == P12PC_ANALOG);
    pins.analog_sel[`P12PC_AN_CH12] = (mode[15] == P12PC_ANALOG);
  end

endmodule // p12pc_pin_mode

`default_nettype wire

// ### verilog/p12pc_pkg.sv
// Types and field decoders for the pin control block.
// Assumes p12pc_defines.svh on the include path.
`include "p12pc_defines.svh"

package p12pc_pkg;

  typedef enum logic [2:0] {
    P12PC_INPUT,
    P12PC_ODRAIN,
    P12PC_PUSH,
    P12PC_ANALOG,
    P12PC_PWM,
    P12PC_NONE
  } p12pc_mode_e;

  // Two-bit pin field; code 10 is analog only where the pin has a channel
  function automatic p12pc_mode_e p12pc_dec2(input logic [1:0] code, input logic has_an);
    p12pc_mode_e m;
    m = P12PC_INPUT;
    unique case (code)
      `P12PC_CODE2_INPUT:  m = P12PC_INPUT;
      `P12PC_CODE2_ODRAIN: m = P12PC_ODRAIN;
      `P12PC_CODE2_ALT:    m = has_an ? P12PC_ANALOG : P12PC_NONE;
      `P12PC_CODE2_PUSH:   m = P12PC_PUSH;
    endcase
    return m;
  endfunction

  // Three-bit field of port 1 pin 1
  function automatic p12pc_mode_e p12pc_dec3(input logic [2:0] code);
    p12pc_mode_e m;
    m = P12PC_PUSH;
    if (!code[2]) begin
      unique case (code[1:0])
        2'h0:    m = P12PC_INPUT;
        2'h1:    m = P12PC_ODRAIN;
        2'h2:    m = P12PC_ANALOG;
        default: m = P12PC_PWM;
      endcase
    end
    return m;
  endfunction

endpackage

// ### verilog/p12pc_top.sv
// Port 1 / port 2 pin control: register file on Avalon-MM and pin drivers.
// Assumes pin inputs synchronous to mclk_in; port 2 data and port 1 pins
// 7..2 direction come from registers outside this block.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module p12pc_top #(
  parameter int ADDR_W = 10
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic [ADDR_W-1:0] address_in,
  input  wire logic              read_in,
  input  wire logic              write_in,
  input  wire logic [31:0]       writedata_in,
  input  wire logic [3:0]        byteenable_in,
  output logic      [31:0]       readdata_out,
  output logic                   waitrequest_out,
  input  wire logic [7:0]        port1_pin_in,
  output logic      [7:0]        port1_pin_out,
  output logic      [7:0]        port1_pin_oe_n_out,
  output logic      [7:0]        port1_pullup_enable_out,
  input  wire logic [5:0]        port1_upper_push_in,
  input  wire logic [7:0]        port2_pin_in,
  output logic      [7:0]        port2_pin_out,
  output logic      [7:0]        port2_pin_oe_n_out,
  input  wire logic [7:0]        port2_data_in,
  input  wire logic              pwm_channel_two_output_in,
  output logic                   external_interrupt_six_out,
  output logic                   external_interrupt_seven_out,
  output logic      [5:0]        analog_select_out
);
  import p12pc_pkg::*;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic        wait_ff;
  logic        nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0]  p1_data_ff;
  logic [7:0]  nxt_p1_data;
  logic [7:0]  p1_ctrl_ff;
  logic [7:0]  nxt_p1_ctrl;
  logic [7:0]  pull_ff;
  logic [7:0]  nxt_pull;
  logic [7:0]  p2l_ff;
  logic [7:0]  nxt_p2l;
  logic [7:0]  p2h_ff;
  logic [7:0]  nxt_p2h;
  logic        req;
  logic        accept;
  logic        wr_lo;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic [7:0]  p1_read;

  p12pc_pin_if pins ();

  assign req    = read_in || write_in;
  assign accept = req && !wait_ff;
  assign idx    = address_in[9:2];
  assign wbyte  = writedata_in[7:0];
  assign wr_lo  = accept && write_in && byteenable_in[0];

  // Open-drain and push-pull pins show the stored bit, all other modes (PWM too) the pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p1_read[i] = pins.out_mode[i] ? p1_data_ff[i] : port1_pin_in[i]; // RQ6
    end
  end

  always_comb begin
    nxt_wait    = !(req && wait_ff);
    nxt_rdata   = rdata_ff;
    nxt_p1_data = p1_data_ff;
    nxt_p1_ctrl = p1_ctrl_ff;
    nxt_pull    = pull_ff;
    nxt_p2l     = p2l_ff;
    nxt_p2h     = p2h_ff;
    if (req && wait_ff && read_in) begin
      unique case (idx)
        `P12PC_IDX_P1_DATA:      nxt_rdata = {24'h000000, p1_read};
        `P12PC_IDX_P1_CTRL_LOW:  nxt_rdata = {24'h000000, p1_ctrl_ff};
        `P12PC_IDX_P1_PULLUP:    nxt_rdata = {24'h000000, pull_ff};
        `P12PC_IDX_P2_CTRL_HIGH: nxt_rdata = {24'h000000, p2h_ff};
        `P12PC_IDX_P2_CTRL_LOW:  nxt_rdata = {24'h000000, p2l_ff};
        default:                 nxt_rdata = 32'h00000000;
      endcase
    end
    if (wr_lo) begin
      unique case (idx)
        `P12PC_IDX_P1_DATA:      nxt_p1_data = wbyte;
        `P12PC_IDX_P1_CTRL_LOW:  nxt_p1_ctrl = wbyte & `P12PC_P1_CTRL_MASK;
        `P12PC_IDX_P1_PULLUP:    nxt_pull    = wbyte; // RQ5
        `P12PC_IDX_P2_CTRL_HIGH: nxt_p2h     = wbyte;
        `P12PC_IDX_P2_CTRL_LOW:  nxt_p2l     = wbyte;
        default:                 nxt_p1_data = p1_data_ff;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wait_ff    <= 1'b1;
      rdata_ff   <= 32'h00000000;
      p1_data_ff <= `P12PC_RST_P1_DATA;      // RQ6
      p1_ctrl_ff <= `P12PC_RST_P1_CTRL_LOW;  // RQ1
      pull_ff    <= `P12PC_RST_P1_PULLUP;    // RQ5
      p2h_ff     <= `P12PC_RST_P2_CTRL_HIGH; // RQ7
      p2l_ff     <= `P12PC_RST_P2_CTRL_LOW;  // RQ9
    end else begin
      wait_ff    <= nxt_wait;
      rdata_ff   <= nxt_rdata;
      p1_data_ff <= nxt_p1_data;
      p1_ctrl_ff <= nxt_p1_ctrl;
      pull_ff    <= nxt_pull;
      p2h_ff     <= nxt_p2h;
      p2l_ff     <= nxt_p2l;
    end
  end

  assign readdata_out            = rdata_ff;
  assign waitrequest_out         = wait_ff;
  assign port1_pullup_enable_out = pull_ff;

  // --------------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------------
  assign pins.p1_ctrl       = p1_ctrl_ff;
  assign pins.p2_ctrl_low   = p2l_ff;
  assign pins.p2_ctrl_high  = p2h_ff;
  assign pins.data          = {port2_data_in, p1_data_ff};
  assign pins.p1_upper_push = port1_upper_push_in;
  assign pins.pwm_level     = pwm_channel_two_output_in;

  p12pc_pin_mode u_pin_mode (
    .pins (pins.dec)
  );

  logic [15:0] pin_ff;
  logic [15:0] nxt_pin;
  logic [15:0] oe_n_ff;
  logic [15:0] nxt_oe_n;
  logic [5:0]  an_ff;
  logic [5:0]  nxt_an;
  logic        external_interrupt_six_ff;
  logic        nxt_external_interrupt_six;
  logic        external_interrupt_seven_ff;
  logic        nxt_external_interrupt_seven;

  always_comb begin
    nxt_pin  = pins.drive_val;
    nxt_oe_n = ~pins.drive_en; // RQ12
    nxt_an   = pins.analog_sel;
    nxt_external_interrupt_six = pins.sense_mode[0] && port1_pin_in[0]; // RQ3
    nxt_external_interrupt_seven = pins.sense_mode[1] && port1_pin_in[1]; // RQ2
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pin_ff  <= 16'h0000;
      oe_n_ff <= 16'hffff;
      an_ff   <= 6'h00;
      external_interrupt_six_ff <= 1'b0;
      external_interrupt_seven_ff <= 1'b0;
    end else begin
      pin_ff  <= nxt_pin;
      oe_n_ff <= nxt_oe_n;
      an_ff   <= nxt_an;
      external_interrupt_six_ff <= nxt_external_interrupt_six;
      external_interrupt_seven_ff <= nxt_external_interrupt_seven;
    end
  end

  assign port1_pin_out                = pin_ff[7:0];
  assign port2_pin_out                = pin_ff[15:8];
  assign port1_pin_oe_n_out           = oe_n_ff[7:0];
  assign port2_pin_oe_n_out           = oe_n_ff[15:8];
  assign analog_select_out            = an_ff;
  assign external_interrupt_six_out   = external_interrupt_six_ff;
  assign external_interrupt_seven_out = external_interrupt_seven_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_bus_answer_one: assert property (
    (req && waitrequest_out) |=> !waitrequest_out ##1 waitrequest_out)
    else $error("waitrequest did not drop for exactly one cycle");

  a_ctrl_reset_vals: assert property ( // RQ1
    $past(!rst_n_in) |-> (p1_ctrl_ff == 8'h00) && (port1_pin_oe_n_out[1:0] == 2'h3))
    else $error("port 1 low control not cleared by reset");

  a_p2_reset_vals: assert property ( // RQ7
    $past(!rst_n_in) |-> (p2h_ff == 8'h55) && (p2l_ff == 8'h55) && (p1_data_ff == 8'hf8))
    else $error("port 2 control or port 1 data reset value wrong");

  a_pin1_push_pull: assert property ( // RQ2
    (p1_ctrl_ff[4] && $stable(p1_ctrl_ff)) |=>
      !port1_pin_oe_n_out[1] && (port1_pin_out[1] == $past(p1_data_ff[1])))
    else $error("pin 1 push-pull not driving its data bit");

  a_pin0_open_drain: assert property ( // RQ11
    (p1_ctrl_ff[1:0] == 2'h1) |=> (port1_pin_oe_n_out[0] == $past(p1_data_ff[0])))
    else $error("pin 0 open-drain enable does not follow data");

  a_pin0_reference: assert property ( // RQ3
    (p1_ctrl_ff[1:0] == 2'h2) |=> port1_pin_oe_n_out[0] && analog_select_out[1])
    else $error("pin 0 reference mode wrong");

  a_pullup_write: assert property ( // RQ5
    (wr_lo && idx == 8'hd6) |=> ##1 (port1_pullup_enable_out == $past(wbyte, 2)))
    else $error("pull-up register write not seen on output");

  a_data_read_pin: assert property ( // RQ6
    (req && waitrequest_out && read_in && idx == 8'hc1 && p1_ctrl_ff[1:0] == 2'h0)
      |=> readdata_out[0] == $past(port1_pin_in[0]))
    else $error("input-mode pin read did not return pin level");

  a_pin4_unavail: assert property ( // RQ12
    (p2h_ff[1:0] == 2'h2) |=> port2_pin_oe_n_out[4])
    else $error("unavailable code drove port 2 pin 4");

  a_p2_analog_nine: assert property ( // RQ10
    (p2l_ff[1:0] == 2'h2) |=> analog_select_out[2] && port2_pin_oe_n_out[0])
    else $error("port 2 pin 0 analog select wrong");

  a_p2_high_analog: assert property ( // RQ8
    (p2h_ff[7:6] == 2'h2) |=> analog_select_out[5] && port2_pin_oe_n_out[7])
    else $error("port 2 pin 7 analog select wrong");

  // --------------------------------------------------------------------------
  // Pin mode and register file assertions
  // --------------------------------------------------------------------------
  a_pin1_pwm_level: assert property ( // RQ2
    (p1_ctrl_ff[4:2] == 3'h3) |=>
      !port1_pin_oe_n_out[1] && (port1_pin_out[1] == $past(pwm_channel_two_output_in)))
    else $error("pin 1 PWM mode not driving the PWM level");

  a_pin1_analog_six: assert property ( // RQ2
    (p1_ctrl_ff[4:2] == 3'h2) |=> port1_pin_oe_n_out[1] && analog_select_out[0])
    else $error("pin 1 analog mode wrong");

  a_pin1_open_drain: assert property ( // RQ11
    (p1_ctrl_ff[4:2] == 3'h1) |=>
      (port1_pin_oe_n_out[1] == $past(p1_data_ff[1])) && !port1_pin_out[1])
    else $error("pin 1 open-drain enable does not follow data");

  a_pin0_push_pull: assert property ( // RQ3
    (p1_ctrl_ff[1:0] == 2'h3) |=>
      !port1_pin_oe_n_out[0] && (port1_pin_out[0] == $past(p1_data_ff[0])))
    else $error("pin 0 push-pull not driving its data bit");

  a_ext_seven_pin: assert property ( // RQ2
    (rst_n_in && p1_ctrl_ff[4:2] == 3'h0) |=> (external_interrupt_seven_out == $past(port1_pin_in[1])))
    else $error("interrupt seven does not follow pin 1 in input mode");

  a_ext_seven_off: assert property ( // RQ2
    (p1_ctrl_ff[4:2] != 3'h0) |=> !external_interrupt_seven_out)
    else $error("interrupt seven active outside input mode");

  a_ext_six_pin: assert property ( // RQ3
    (rst_n_in && p1_ctrl_ff[1:0] == 2'h0) |=> (external_interrupt_six_out == $past(port1_pin_in[0])))
    else $error("interrupt six does not follow pin 0 in input mode");

  a_ext_six_off: assert property ( // RQ3
    (p1_ctrl_ff[1:0] != 2'h0) |=> !external_interrupt_six_out)
    else $error("interrupt six active outside input mode");

  a_p2_open_drain: assert property ( // RQ11
    (rst_n_in && p2l_ff[7:6] == 2'h1) |=>
      (port2_pin_oe_n_out[3] == $past(port2_data_in[3])) && !port2_pin_out[3])
    else $error("port 2 pin 3 open-drain enable does not follow data");

  a_p2_push_pull: assert property ( // RQ8
    (p2h_ff[3:2] == 2'h3) |=>
      !port2_pin_oe_n_out[5] && (port2_pin_out[5] == $past(port2_data_in[5])))
    else $error("port 2 pin 5 push-pull not driving its data bit");

  a_p2_analog_ten: assert property ( // RQ8
    (p2h_ff[3:2] == 2'h2) |=> analog_select_out[3] && port2_pin_oe_n_out[5])
    else $error("port 2 pin 5 analog select wrong");

  a_p2_high_input: assert property ( // RQ8
    (p2h_ff[7:6] == 2'h0) |=> port2_pin_oe_n_out[7] && !analog_select_out[5])
    else $error("port 2 pin 7 input mode drives the pin");

  a_p2_low_input: assert property ( // RQ10
    (p2l_ff[3:2] == 2'h0) |=> port2_pin_oe_n_out[1])
    else $error("port 2 pin 1 input mode drives the pin");

  a_p2_low_unavail: assert property ( // RQ12
    (p2l_ff[5:4] == 2'h2) |=> port2_pin_oe_n_out[2])
    else $error("unavailable code drove port 2 pin 2");

  a_data_write: assert property ( // RQ6
    (wr_lo && idx == 8'hc1) |=> (p1_data_ff == $past(wbyte)))
    else $error("port 1 data write not stored");

  a_byteen_ignored: assert property (
    (accept && write_in && !byteenable_in[0]) |=> $stable(pull_ff) && $stable(p1_ctrl_ff))
    else $error("write without byte enable changed a register");

  a_unmapped_zero: assert property (
    (req && waitrequest_out && read_in && idx == 8'h00) |=> (readdata_out == 32'h00000000))
    else $error("unmapped read returned nonzero data");

  c_write_accept: cover property (wr_lo ##1 waitrequest_out);
  c_read_accept:  cover property (accept && read_in);
  c_pwm_drive:    cover property (p1_ctrl_ff[4:2] == 3'h3 ##1 !port1_pin_oe_n_out[1]);
  c_external_interrupt_seven_event:   cover property (external_interrupt_seven_out);
  c_p2_push:      cover property (p2h_ff == 8'hff ##1 !port2_pin_oe_n_out[7]);

endmodule // p12pc_top

`default_nettype wire
